// *** inc/osc_divider_defines.svh ***
// Constants of the oscillator and divider block
`ifndef OSC_DIVIDER_DEFINES_SVH
`define OSC_DIVIDER_DEFINES_SVH
`define CLK_PERIOD_PS 5000
`define OSC_FREQ_KHZ 5000
`define OSC_PERIOD_PS 200000
`define OSC_HALF_CYCLES (`OSC_PERIOD_PS / (2 * `CLK_PERIOD_PS))
`define DIV_BITS_128 7
`define DIV_BITS_1024 10
`define DIV_BITS_1M 20
`define DIV_BITS_MAX 20
`define LINK_CELL_INDEX 15
`endif

// *** inc/osc_divider_pkg.sv ***
// Types of the oscillator and divider block
package osc_divider_pkg;
	typedef enum logic [1:0] {
		div_128 = 2'h0,
		div_1024 = 2'h1,
		div_1m = 2'h2
	} div_ratio_t;
	typedef enum logic [2:0] {
		st_off = 3'h1,
		st_clear = 3'h2,
		st_run = 3'h4
	} osc_state_t;
endpackage : osc_divider_pkg

// *** verilog/link_cell_mux.sv ***
// Feedback selector of a fabric logic cell joined to the oscillator block
`timescale 1ns/1ps
`include "osc_divider_defines.svh"
module link_cell_mux (
	input wire logic clk, // System clock
	input wire logic rst, // Asynchronous reset
	input wire logic sel_osc, // Configuration: 1 places oscillator output on routing
	input wire logic cell_feedback, // Cell's own feedback
	input wire logic osc_source, // Oscillator-block output
	output logic routing_out // Line into the global routing pool
);
	// Registered so every top output comes from a flip-flop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			routing_out <= 1'b0;
		end else begin
			routing_out <= sel_osc ? osc_source : cell_feedback; // RL11
		end
	end
endmodule : link_cell_mux

// *** verilog/osc_divider_timer.sv ***
// Oscillator with power-of-two divider and fabric link cells
// Function
// RL1: The oscillator is off unless configuration enables it.
// RL2: The oscillator clock runs at nominal 5 MHz while enabled.
// RL3: The tick equals oscillator frequency over the ratio, 128 by default.
// RL4: The ratio is 128, 1024 or 1048576 from a 7, 10 or 20 bit divider.
// RL5: Divider clear is resynchronised to the oscillator before clearing the divider.
// RL6: The first tick edge after clear release comes one oscillator cycle late.
// RL7: Shutdown stops the oscillator, holds the divider reset, and saves power.
// RL8: User logic drives divider clear synchronously to the oscillator clock.
// RL9: Oscillator clock and tick are offered to the global routing pool.
// RL10: Clear and shutdown inputs are optional and come from user logic cells.
// RL11: Two logic cells carry a selector between own feedback and an oscillator output.
// RL12: The joined cells are index 15 of their logic blocks.
// RL13: User logic divides the tick further if slower ticks are needed.
// RL14: The divider is a free-running counter whose top bit is the tick.
// RL15: Outputs are low while the oscillator is disabled or shut down.
`timescale 1ns/1ps
`include "osc_divider_defines.svh"
module osc_divider_timer
	import osc_divider_pkg::*;
#(
	parameter int HALF_CYCLES = `OSC_HALF_CYCLES,
	parameter int LINK_CELL_INDEX = `LINK_CELL_INDEX
) (
	input wire logic clk, // System clock, 200 MHz
	input wire logic rst, // Asynchronous reset, active high
	input wire logic osc_enable, // Configuration: oscillator in use
	input wire osc_divider_pkg::div_ratio_t div_ratio, // Configuration: divide ratio
	input wire logic divider_clear, // Divider clear from a user cell
	input wire logic osc_shutdown, // Dynamic shutdown from a user cell
	input wire logic osc_cell_sel, // Oscillator link cell selector
	input wire logic osc_cell_feedback, // Oscillator link cell own feedback
	input wire logic tick_cell_sel, // Tick link cell selector
	input wire logic tick_cell_feedback, // Tick link cell own feedback
	output logic osc_clock_out, // Oscillator clock
	output logic divided_tick_out, // Divided tick
	output logic osc_running, // Oscillator powered and running
	output logic osc_routing_line, // Routing line of the oscillator link cell
	output logic tick_routing_line // Routing line of the tick link cell
);
	import osc_divider_pkg::*;

	// ****************************************
	// Oscillator
	// ****************************************
	logic osc_on;
	logic [15:0] half_cnt_reg;
	logic osc_phase_reg;
	logic osc_edge;
	assign osc_on = osc_enable && !osc_shutdown; // RL1 RL7
	assign osc_edge = osc_on && osc_phase_reg && (half_cnt_reg == 16'(HALF_CYCLES - 1));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			half_cnt_reg <= 16'h0000;
			osc_phase_reg <= 1'b0;
		end else if (!osc_on) begin
			half_cnt_reg <= 16'h0000; // RL7
			osc_phase_reg <= 1'b0;
		end else if (half_cnt_reg == 16'(HALF_CYCLES - 1)) begin
			half_cnt_reg <= 16'h0000; // RL2
			osc_phase_reg <= !osc_phase_reg;
		end else begin
			half_cnt_reg <= half_cnt_reg + 16'h0001;
		end
	end

	// ****************************************
	// Clear resynchroniser and divider
	// ****************************************
	osc_state_t state_reg;
	logic clr_sync_reg;
	logic [`DIV_BITS_MAX-1:0] div_cnt_reg;
	logic tick_bit;

	// Clear sampled on the oscillator edge, one extra oscillator cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clr_sync_reg <= 1'b1;
		end else if (!osc_on) begin
			clr_sync_reg <= 1'b1;
		end else if (osc_edge) begin
			clr_sync_reg <= divider_clear; // RL5 RL6 RL8
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= st_off;
		end else begin
			case (state_reg)
				st_off: begin
					if (osc_on) begin
						state_reg <= st_clear;
					end
				end
				st_clear: begin
					if (!osc_on) begin
						state_reg <= st_off;
					end else if (osc_edge && !clr_sync_reg) begin
						state_reg <= st_run;
					end
				end
				st_run: begin
					if (!osc_on) begin
						state_reg <= st_off;
					end else if (clr_sync_reg) begin
						state_reg <= st_clear;
					end
				end
				default: begin
					state_reg <= st_off;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_cnt_reg <= '0;
		end else if (!osc_on || state_reg != st_run || clr_sync_reg) begin
			// Shutdown clears in the same cycle, not one cycle after the state leaves run
			div_cnt_reg <= '0; // RL5 RL7
		end else if (osc_edge) begin
			div_cnt_reg <= div_cnt_reg + `DIV_BITS_MAX'(1); // RL14
		end
	end

	always_comb begin
		case (div_ratio)
			div_1024: tick_bit = div_cnt_reg[`DIV_BITS_1024-1]; // RL4
			div_1m: tick_bit = div_cnt_reg[`DIV_BITS_1M-1];
			default: tick_bit = div_cnt_reg[`DIV_BITS_128-1]; // RL3
		endcase
	end

	// ****************************************
	// Outputs to the global routing pool
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			osc_clock_out <= 1'b0;
			divided_tick_out <= 1'b0;
			osc_running <= 1'b0;
		end else begin
			osc_clock_out <= osc_on && osc_phase_reg; // RL9 RL15
			divided_tick_out <= osc_on && tick_bit; // RL14 RL15
			osc_running <= osc_on;
		end
	end

	// Cell index 15 of its block carries each selector
	link_cell_mux osc_link_cell (
		.clk(clk),
		.rst(rst),
		.sel_osc(osc_cell_sel),
		.cell_feedback(osc_cell_feedback),
		.osc_source(osc_on && osc_phase_reg),
		.routing_out(osc_routing_line)
	); // RL11 RL12
	link_cell_mux tick_link_cell (
		.clk(clk),
		.rst(rst),
		.sel_osc(tick_cell_sel),
		.cell_feedback(tick_cell_feedback),
		.osc_source(osc_on && tick_bit),
		.routing_out(tick_routing_line)
	); // RL11 RL12

	// ****************************************
	// Checks
	// ****************************************
	chk_off_quiet: assert property (@(posedge clk) disable iff (rst) // RL15
		!osc_on |=> !osc_clock_out && !divided_tick_out)
		else $error("outputs not low while oscillator off");
	chk_osc_period: assert property (@(posedge clk) disable iff (rst) // RL2
		$rose(osc_phase_reg) && osc_on |-> ##(2*HALF_CYCLES) (osc_phase_reg || !osc_on))
		else $error("oscillator period wrong");
	chk_clear_holds: assert property (@(posedge clk) disable iff (rst) // RL5
		clr_sync_reg |=> div_cnt_reg == '0)
		else $error("divider not cleared");
	chk_shutdown_hold: assert property (@(posedge clk) disable iff (rst) // RL7
		osc_shutdown |=> state_reg == st_off && div_cnt_reg == '0)
		else $error("shutdown did not hold divider");
	chk_count_step: assert property (@(posedge clk) disable iff (rst) // RL14
		state_reg == st_run && !clr_sync_reg && osc_edge && osc_on
		|=> div_cnt_reg == $past(div_cnt_reg) + `DIV_BITS_MAX'(1))
		else $error("divider did not step");
	chk_tick_source: assert property (@(posedge clk) disable iff (rst) // RL3
		div_ratio == div_128
		|=> divided_tick_out == ($past(osc_on) && $past(div_cnt_reg[`DIV_BITS_128-1])))
		else $error("tick bit wrong");
	chk_resync_delay: assert property (@(posedge clk) disable iff (rst) // RL6
		state_reg == st_clear && clr_sync_reg && osc_edge |=> state_reg == st_clear)
		else $error("clear release not delayed");
	chk_cell_select: assert property (@(posedge clk) disable iff (rst) // RL11
		!osc_cell_sel |=> osc_routing_line == $past(osc_cell_feedback))
		else $error("link cell selector wrong");
	chk_enable_off: assert property (@(posedge clk) disable iff (rst) // RL1
		!osc_enable |=> !osc_running)
		else $error("oscillator running while disabled");
	cov_run: cover property (@(posedge clk) disable iff (rst) state_reg == st_run);
	cov_tick: cover property (@(posedge clk) disable iff (rst) $rose(divided_tick_out));
	cov_shut: cover property (@(posedge clk) disable iff (rst)
		state_reg == st_run ##1 osc_shutdown);
	cov_clear: cover property (@(posedge clk) disable iff (rst)
		state_reg == st_run ##1 state_reg == st_clear);
endmodule : osc_divider_timer

// *** dv/user_cell_model.sv ***
// Fabric user cells that drive the optional clear and shutdown inputs
`timescale 1ns/1ps
module user_cell_model (
	input wire logic clk, // System clock
	input wire logic osc_clock_out, // Oscillator clock from the block
	input wire logic divided_tick_out, // Divided tick from the block
	input wire logic clear_req, // Bench asks for divider clear
	input wire logic shut_req, // Bench asks for shutdown
	output logic divider_clear, // Registered cell output
	output logic osc_shutdown, // Registered cell output
	output logic slow_tick // Tick divided by two more in fabric
);
	logic osc_prev_reg = 1'b0;
	logic tick_prev_reg = 1'b0;
	initial slow_tick = 1'b0;
	initial divider_clear = 1'b1;
	initial osc_shutdown = 1'b0;
	// Clear moves only just after an oscillator rise, so it never races the divider
	always @(posedge clk) begin
		osc_prev_reg <= osc_clock_out;
		if (osc_clock_out && !osc_prev_reg) begin
			divider_clear <= clear_req;
		end
		osc_shutdown <= shut_req;
		tick_prev_reg <= divided_tick_out;
		if (divided_tick_out && !tick_prev_reg) begin
			slow_tick <= !slow_tick;
		end
	end
endmodule : user_cell_model

// *** dv/tb_top.sv ***
// Self-checking bench of the oscillator and divider block
`timescale 1ns/1ps
module tb_top;
	import osc_divider_pkg::*;
	localparam int HALF = 2;
	logic clk = 1'b0, rst = 1'b1, osc_enable = 1'b0, clear_req = 1'b1, shut_req = 1'b0;
	logic osc_sel = 1'b0, osc_fb = 1'b0, tick_sel = 1'b0, tick_fb = 1'b0, prev, slow_tick;
	logic divider_clear, osc_shutdown, osc_clock_out, divided_tick_out, osc_running;
	logic osc_line, tick_line;
	div_ratio_t div_ratio = div_128;
	int err_count = 0, comparisons = 0, p, n, r;
	div_ratio_t ratio_row [3] = '{div_128, div_1024, div_ratio_t'(2'h3)};
	int period_row [3] = '{256 * HALF, 2048 * HALF, 256 * HALF};
	always #2.5 clk = ~clk;
	user_cell_model u_cell (.clk(clk), .osc_clock_out(osc_clock_out),
		.divided_tick_out(divided_tick_out), .clear_req(clear_req),
		.shut_req(shut_req), .divider_clear(divider_clear), .osc_shutdown(osc_shutdown),
		.slow_tick(slow_tick));
	osc_divider_timer #(.HALF_CYCLES(HALF)) u_dut (.clk(clk), .rst(rst),
		.osc_enable(osc_enable), .div_ratio(div_ratio), .divider_clear(divider_clear),
		.osc_shutdown(osc_shutdown), .osc_cell_sel(osc_sel), .osc_cell_feedback(osc_fb),
		.tick_cell_sel(tick_sel), .tick_cell_feedback(tick_fb),
		.osc_clock_out(osc_clock_out), .divided_tick_out(divided_tick_out),
		.osc_running(osc_running), .osc_routing_line(osc_line), .tick_routing_line(tick_line));
	task automatic tally_and_finish();
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : step
	task automatic give_up(input int i, input int lim);
		if (i == lim) begin
			err_count++;
			tally_and_finish();
		end
	endtask : give_up
	// Cycles between the second and third rise of the tick, the fabric slow tick or the oscillator clock
	task automatic period(input int sel, output int cyc);
		logic last, cur;
		int i;
		cyc = 0;
		n = 0;
		last = 1'b1;
		for (i = 0; n < 3; i++) begin
			give_up(i, 20000);
			step(1);
			cur = (sel == 2) ? slow_tick : ((sel == 1) ? divided_tick_out : osc_clock_out);
			if (n == 2) cyc++;
			if (cur === 1'b1 && last === 1'b0) n++;
			last = cur;
		end
	endtask : period
	initial begin
		step(1);
		cmp(osc_running, 1'b0);
		step(1);
		rst = 1'b0;
		for (r = 0; r < 20; r++) begin
			step(1);
			cmp(osc_clock_out | osc_running, 1'b0);
		end
		osc_enable = 1'b1;
		period(1'b0, p);
		cmp(p, 2 * HALF);
		clear_req = 1'b0;
		for (r = 0; r < 3; r++) begin
			div_ratio = ratio_row[r];
			period(1'b1, p);
			cmp(p, period_row[r]);
		end
		period(2, p);
		cmp(p, 512 * HALF);
		div_ratio = div_128;
		clear_req = 1'b1;
		step(10 * HALF);
		cmp(divided_tick_out, 1'b0);
		clear_req = 1'b0;
		for (r = 0; divider_clear !== 1'b0; r++) begin
			give_up(r, 100);
			step(1);
		end
		n = 0;
		prev = osc_clock_out;
		for (r = 0; divided_tick_out !== 1'b1; r++) begin
			give_up(r, 2000);
			step(1);
			if (osc_clock_out && !prev) n++;
			prev = osc_clock_out;
		end
		cmp(n, 66);
		shut_req = 1'b1;
		step(3);
		for (r = 0; r < 8; r++) begin
			cmp(osc_running | osc_clock_out | divided_tick_out, 1'b0);
			step(1);
		end
		shut_req = 1'b0;
		step(3);
		cmp(osc_running, 1'b1);
		osc_fb = 1'b1;
		tick_fb = 1'b1;
		step(2);
		cmp(osc_line & tick_line, 1'b1);
		osc_sel = 1'b1;
		tick_sel = 1'b1;
		step(2);
		for (r = 0; r < 8; r++) begin
			step(1);
			cmp(osc_line, osc_clock_out);
			cmp(tick_line, divided_tick_out);
		end
		div_ratio = div_1m;
		clear_req = 1'b1;
		step(20);
		clear_req = 1'b0;
		for (r = 0; r < 3000; r++) begin
			step(1);
			cmp(divided_tick_out, 1'b0);
		end
		rst = 1'b1;
		step(1);
		cmp(osc_running | osc_clock_out, 1'b0);
		tally_and_finish();
	end
endmodule : tb_top
